// ==== hw/adc_serial_pkg.sv ====
// shared constants and carriers for the converter serial readout
package adc_serial_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ        = 50000000;

  // frame layout: status flag then result bits
  localparam int FRAME_BITS = 24;
  localparam int RESULT_W   = FRAME_BITS - 1;
  localparam int FIFO_DEPTH = 8;

  // internal serial clock is the core clock divided by eight
  localparam int SCK_DIV  = 8;
  localparam int SCK_HALF = SCK_DIV / 2;

  // power-on reset length
  localparam int POR_TIME_NS = 500000;
  localparam int POR_CYCLES  = POR_TIME_NS / CLK_PERIOD_NS;

  // status test delay on the internal oscillator (least time, round up)
  localparam int STATUS_TEST_DELAY_NS = 23000;
  localparam int STATUS_TEST_CYCLES   =
    (STATUS_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // status test delay on an external oscillator: 3.6 periods
  localparam int EXT_OSC_PERIODS_X10 = 36;
  localparam int EXT_OSC_HZ_DEFAULT  = 307200;

  localparam int DLY_W = 12;

  // serial clock source selection
  typedef enum logic [1:0] {
    MODE_EXT        = 2'b00,
    MODE_INT_SINGLE = 2'b01,
    MODE_INT_CONT   = 2'b11
  } clk_mode_t;

  // readout sequence, gray coded along convert-sleep-test-output
  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_TEST    = 2'b11,
    ST_OUTPUT  = 2'b10
  } rd_state_t;

  // pin drive group
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sck_pullup;
    logic sdo;
    logic sdo_oe;
  } pin_out_t;

endpackage

// ==== hw/adc_result_fifo.sv ====
// result buffer between the converter core and the serial readout
`timescale 1ns/1ps
module adc_result_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             ready_r;

  wire push = i_in_valid & ready_r;
  wire pop  = i_out_ready & (count_r != '0);

  assign count_nxt   = count_r + CW'(push) - CW'(pop);
  assign o_in_ready  = ready_r;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      ready_r <= (count_nxt != DEPTH_C);
    end

  always_ff @(posedge i_core_clk)
    if (push)
      mem_r[wr_ptr_r] <= i_in_data;

endmodule

// ==== hw/adc_serial_readout.sv ====
// serial readout of the delta-sigma converter: clock mode, status flag, frame
`timescale 1ns/1ps
module adc_serial_readout #(
  parameter int POR_CYCLES = adc_serial_pkg::POR_CYCLES,
  parameter int EXT_OSC_HZ = adc_serial_pkg::EXT_OSC_HZ_DEFAULT,
  parameter int RESULT_W   = adc_serial_pkg::RESULT_W,
  parameter int FIFO_DEPTH = adc_serial_pkg::FIFO_DEPTH
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sck,
  input  wire logic                    i_ext_osc,
  input  wire logic                    i_result_valid,
  input  wire logic [RESULT_W-1:0]     i_result_data,
  output logic                         o_result_ready,
  output logic                         o_conv_start,
  output logic                         o_eoc,
  output adc_serial_pkg::clk_mode_t    o_clk_mode,
  output adc_serial_pkg::pin_out_t     o_pins
);
  localparam int PCW = $clog2(POR_CYCLES + 1);
  localparam logic [PCW-1:0] POR_LAST = PCW'(POR_CYCLES - 1);

  localparam int BCW = $clog2(adc_serial_pkg::FRAME_BITS + 1);
  localparam logic [BCW-1:0] FRAME_C = BCW'(adc_serial_pkg::FRAME_BITS);

  localparam int PHW = $clog2(adc_serial_pkg::SCK_HALF);
  localparam logic [PHW-1:0] PH_LAST = PHW'(adc_serial_pkg::SCK_HALF - 1);

  localparam int DW = adc_serial_pkg::DLY_W;
  localparam int EXT_DLY_CYC =
    (adc_serial_pkg::EXT_OSC_PERIODS_X10 * (adc_serial_pkg::CLK_HZ / 10)
     + EXT_OSC_HZ - 1) / EXT_OSC_HZ;
  localparam logic [DW-1:0] INT_DLY_C =
    DW'(adc_serial_pkg::STATUS_TEST_CYCLES - 1);
  localparam logic [DW-1:0] EXT_DLY_C  = DW'(EXT_DLY_CYC - 1);
  localparam logic [DW-1:0] HALF_DLY_C = DW'(adc_serial_pkg::SCK_HALF - 1);

  // true when the mode generates the serial clock itself
  function automatic logic is_internal(input adc_serial_pkg::clk_mode_t m);
    return m != adc_serial_pkg::MODE_EXT;
  endfunction

  // shift register after its top bit has left on the data pin
  function automatic logic [RESULT_W-1:0] shift_once(
    input logic [RESULT_W-1:0] v
  );
    return {v[RESULT_W-2:0], 1'b0};
  endfunction

  // state
  adc_serial_pkg::rd_state_t state_r, state_nxt;
  adc_serial_pkg::clk_mode_t mode_r,  mode_nxt;
  adc_serial_pkg::pin_out_t  pins_r,  pins_nxt;
  logic [PCW-1:0]      por_cnt_r;
  logic                por_active_r;
  logic                cs_q_r;
  logic                sck_q_r;
  logic [RESULT_W-1:0] shreg_r,   shreg_nxt;
  logic [BCW-1:0]      bit_cnt_r, bit_cnt_nxt;
  logic [PHW-1:0]      ph_r,      ph_nxt;
  logic [DW-1:0]       dly_r,     dly_nxt;
  logic                start_r,   start_nxt;
  logic                pop;

  // buffer output
  logic                fifo_valid;
  logic [RESULT_W-1:0] fifo_data;

  // pin edge detection
  wire cs_fall  = cs_q_r & ~i_cs_n;
  wire cs_rise  = ~cs_q_r & i_cs_n;
  wire ext_rise = ~sck_q_r & i_sck;
  wire ext_fall = sck_q_r & ~i_sck;
  wire por_end  = por_active_r & (por_cnt_r == POR_LAST);

  // clock source picked at a select falling edge or at reset end
  wire adc_serial_pkg::clk_mode_t cs_sel_mode = i_sck ?
    adc_serial_pkg::MODE_INT_SINGLE : adc_serial_pkg::MODE_EXT;
  wire adc_serial_pkg::clk_mode_t por_sel_mode = i_sck ?
    adc_serial_pkg::MODE_INT_CONT : adc_serial_pkg::MODE_EXT;

  // status test length depends on oscillator source
  wire [DW-1:0] test_dly = i_ext_osc ? EXT_DLY_C : INT_DLY_C;

  wire single_mode = (mode_nxt == adc_serial_pkg::MODE_INT_SINGLE);
  wire cont_mode   = (mode_nxt == adc_serial_pkg::MODE_INT_CONT);

  // pin enables and pull-up decoded ahead of the output register
  wire sdo_oe_nxt = !i_cs_n && !por_active_r;
  wire sck_oe_nxt = !por_active_r &&
    (cont_mode || (single_mode && !i_cs_n));
  wire pullup_nxt = por_active_r || i_sck ||
    (cs_rise && state_r == adc_serial_pkg::ST_TEST);

  // frame end and bit decodes
  wire ext_last_fall = ext_fall && (bit_cnt_r == FRAME_C);
  wire int_last_rise = (bit_cnt_r + 1'b1 == FRAME_C);
  wire ph_tick       = (ph_r == PH_LAST);
  wire shreg_msb     = shreg_r[RESULT_W-1];

  adc_result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_result_valid),
    .o_in_ready  (o_result_ready),
    .i_in_data   (i_result_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_data)
  );

  // mode reselection
  always_comb
  begin
    mode_nxt = mode_r;
    if (por_end)
      mode_nxt = por_sel_mode;
    else if (!por_active_r && cs_fall)
      mode_nxt = cs_sel_mode;
  end

  // readout sequence
  always_comb
  begin
    state_nxt   = state_r;
    shreg_nxt   = shreg_r;
    bit_cnt_nxt = bit_cnt_r;
    ph_nxt      = ph_r;
    dly_nxt     = dly_r;
    start_nxt   = 1'b0;
    pop         = 1'b0;
    pins_nxt    = pins_r;
    if (por_active_r)
    begin
      state_nxt    = adc_serial_pkg::ST_CONVERT;
      pins_nxt.sck = 1'b1;
      pins_nxt.sdo = 1'b1;
      start_nxt    = por_end;
    end
    else
    begin
      unique case (state_r)
        adc_serial_pkg::ST_CONVERT:
        begin
          pins_nxt.sdo = 1'b1;
          if (cont_mode)
            pins_nxt.sck = 1'b1;
          else if (single_mode && cs_fall)
            pins_nxt.sck = 1'b0;
          if (fifo_valid)
          begin
            pop          = 1'b1;
            shreg_nxt    = fifo_data;
            pins_nxt.sdo = 1'b0;
            if (cont_mode)
            begin
              pins_nxt.sck = 1'b0;
              dly_nxt      = HALF_DLY_C;
              state_nxt    = adc_serial_pkg::ST_TEST;
            end
            else if (single_mode && !i_cs_n)
            begin
              pins_nxt.sck = 1'b0;
              dly_nxt      = test_dly;
              state_nxt    = adc_serial_pkg::ST_TEST;
            end
            else
              state_nxt = adc_serial_pkg::ST_SLEEP;
          end
        end
        adc_serial_pkg::ST_SLEEP:
        begin
          pins_nxt.sdo = 1'b0;
          if (cs_fall && cs_sel_mode == adc_serial_pkg::MODE_INT_SINGLE)
          begin
            pins_nxt.sck = 1'b0;
            dly_nxt      = test_dly;
            state_nxt    = adc_serial_pkg::ST_TEST;
          end
          else if (cont_mode)
          begin
            pins_nxt.sck = 1'b0;
            dly_nxt      = HALF_DLY_C;
            state_nxt    = adc_serial_pkg::ST_TEST;
          end
          else if (!is_internal(mode_nxt) && !i_cs_n && ext_rise)
          begin
            bit_cnt_nxt = BCW'(1);
            state_nxt   = adc_serial_pkg::ST_OUTPUT;
          end
        end
        adc_serial_pkg::ST_TEST:
        begin
          pins_nxt.sdo = 1'b0;
          pins_nxt.sck = 1'b0;
          if (single_mode && i_cs_n)
            state_nxt = adc_serial_pkg::ST_SLEEP;
          else if (dly_r == '0)
          begin
            pins_nxt.sck = 1'b1;
            bit_cnt_nxt  = BCW'(1);
            ph_nxt       = '0;
            state_nxt    = adc_serial_pkg::ST_OUTPUT;
          end
          else
            dly_nxt = dly_r - 1'b1;
        end
        adc_serial_pkg::ST_OUTPUT:
        begin
          if (cs_rise)
          begin
            pins_nxt.sdo = 1'b1;
            start_nxt    = 1'b1;
            state_nxt    = adc_serial_pkg::ST_CONVERT;
          end
          else if (!is_internal(mode_nxt))
          begin
            if (ext_rise && bit_cnt_r != FRAME_C)
              bit_cnt_nxt = bit_cnt_r + 1'b1;
            if (ext_last_fall)
            begin
              pins_nxt.sdo = 1'b1;
              start_nxt    = 1'b1;
              state_nxt    = adc_serial_pkg::ST_CONVERT;
            end
            else if (ext_fall)
            begin
              pins_nxt.sdo = shreg_msb;
              shreg_nxt    = shift_once(shreg_r);
            end
          end
          else if (!ph_tick)
            ph_nxt = ph_r + 1'b1;
          else
          begin
            ph_nxt = '0;
            if (pins_r.sck)
            begin
              pins_nxt.sck = 1'b0;
              pins_nxt.sdo = shreg_msb;
              shreg_nxt    = shift_once(shreg_r);
            end
            else
            begin
              pins_nxt.sck = 1'b1;
              bit_cnt_nxt  = bit_cnt_r + 1'b1;
              if (int_last_rise)
              begin
                start_nxt = 1'b1;
                state_nxt = adc_serial_pkg::ST_CONVERT;
              end
            end
          end
        end
      endcase
    end
    pins_nxt.sdo_oe     = sdo_oe_nxt;
    pins_nxt.sck_oe     = sck_oe_nxt;
    pins_nxt.sck_pullup = pullup_nxt;
  end

  // power-on reset timer
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      por_cnt_r    <= '0;
      por_active_r <= 1'b1;
    end
    else if (por_active_r)
    begin
      por_cnt_r    <= por_cnt_r + 1'b1;
      por_active_r <= !por_end;
    end

  // pin history and mode
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      cs_q_r  <= 1'b1;
      sck_q_r <= 1'b1;
      mode_r  <= adc_serial_pkg::MODE_INT_CONT;
    end
    else
    begin
      cs_q_r  <= i_cs_n;
      sck_q_r <= i_sck;
      mode_r  <= mode_nxt;
    end

  // sequence registers
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      state_r   <= adc_serial_pkg::ST_CONVERT;
      shreg_r   <= '0;
      bit_cnt_r <= '0;
    end
    else
    begin
      state_r   <= state_nxt;
      shreg_r   <= shreg_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end

  // clock phase, delay timer and conversion start
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      ph_r    <= '0;
      dly_r   <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      ph_r    <= ph_nxt;
      dly_r   <= dly_nxt;
      start_r <= start_nxt;
    end

  // output registers
  always_ff @(posedge i_core_clk or posedge i_reset)
    if (i_reset)
    begin
      pins_r     <= '{sck: 1'b1, sck_oe: 1'b0, sck_pullup: 1'b1,
                      sdo: 1'b1, sdo_oe: 1'b0};
      o_eoc      <= 1'b1;
      o_clk_mode <= adc_serial_pkg::MODE_INT_CONT;
    end
    else
    begin
      pins_r     <= pins_nxt;
      o_eoc      <= (state_nxt == adc_serial_pkg::ST_CONVERT);
      o_clk_mode <= mode_nxt;
    end

  assign o_pins       = pins_r;
  assign o_conv_start = start_r;

endmodule

// ==== dv/adc_serial_chk.sv ====
// assertion checker for the converter serial readout ports
`timescale 1ns/1ps
module adc_serial_chk #(
  parameter int POR_CYCLES = 20,
  parameter int EXT_OSC_HZ = 307200,
  parameter int RESULT_W   = 23,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                      i_core_clk,
  input wire logic                      i_reset,
  input wire logic                      i_cs_n,
  input wire logic                      i_sck,
  input wire logic                      i_ext_osc,
  input wire logic                      i_result_valid,
  input wire logic [RESULT_W-1:0]       i_result_data,
  input wire logic                      o_result_ready,
  input wire logic                      o_conv_start,
  input wire logic                      o_eoc,
  input wire adc_serial_pkg::clk_mode_t o_clk_mode,
  input wire adc_serial_pkg::pin_out_t  o_pins
);
  localparam int INT_DLY = adc_serial_pkg::STATUS_TEST_CYCLES;
  localparam int EXT_DLY = (adc_serial_pkg::EXT_OSC_PERIODS_X10 *
    adc_serial_pkg::CLK_HZ + 10 * EXT_OSC_HZ - 1) / (10 * EXT_OSC_HZ);
  logic        por_done_r;
  logic [11:0] low_cnt_r;
  int          dly;
  assign dly = i_ext_osc ? EXT_DLY : INT_DLY;
  // counts cycles the serial clock is driven low
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      por_done_r <= 1'b0;
      low_cnt_r  <= 12'h000;
    end
    else
    begin
      if (o_conv_start)
        por_done_r <= 1'b1;
      low_cnt_r <= (o_pins.sck_oe && !o_pins.sck) ?
        low_cnt_r + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_por_mode;
    o_conv_start && !por_done_r |-> o_clk_mode == ($past(i_sck) ?
      adc_serial_pkg::MODE_INT_CONT : adc_serial_pkg::MODE_EXT);
  endproperty
  a_por_mode: assert property (p_por_mode)
    else $error("clock mode after power-on reset is wrong");
  property p_pu_por;
    !por_done_r |-> o_pins.sck_pullup;
  endproperty
  a_pu_por: assert property (p_pu_por)
    else $error("pull-up off during power-on reset");
  property p_pu_low;
    por_done_r && !i_sck && !$rose(i_cs_n) |=> !o_pins.sck_pullup;
  endproperty
  a_pu_low: assert property (p_pu_low)
    else $error("pull-up on while clock pin low");
  property p_cs_mode;
    $fell(i_cs_n) && por_done_r |=>
      (o_clk_mode == adc_serial_pkg::MODE_EXT) == !$past(i_sck);
  endproperty
  a_cs_mode: assert property (p_cs_mode)
    else $error("clock mode after select fall is wrong");
  property p_sdo_hiz;
    i_cs_n && $past(i_cs_n) &&
      o_clk_mode == adc_serial_pkg::MODE_INT_SINGLE |-> !o_pins.sdo_oe;
  endproperty
  a_sdo_hiz: assert property (p_sdo_hiz)
    else $error("data pin driven while select high");
  property p_eoc_sdo;
    o_eoc && $past(o_eoc) && !i_cs_n && o_pins.sdo_oe |-> o_pins.sdo;
  endproperty
  a_eoc_sdo: assert property (p_eoc_sdo)
    else $error("data pin low while converting");
  property p_div8;
    $rose(o_pins.sck) && o_pins.sck_oe &&
      o_clk_mode != adc_serial_pkg::MODE_EXT |->
      (##[0:4] o_conv_start) or (##1 o_pins.sck [*3] ##1 !o_pins.sck);
  endproperty
  a_div8: assert property (p_div8)
    else $error("internal clock high phase not four cycles");
  property p_test_dly;
    $rose(o_pins.sck) && o_pins.sck_oe && low_cnt_r > 12'h064 |->
      low_cnt_r + 3 >= dly && low_cnt_r <= dly + 3;
  endproperty
  a_test_dly: assert property (p_test_dly)
    else $error("status test delay length wrong");
  property p_cont_sleep;
    $fell(o_eoc) && o_clk_mode == adc_serial_pkg::MODE_INT_CONT |->
      (!o_pins.sck && !o_pins.sdo) [*4] ##1 o_pins.sck;
  endproperty
  a_cont_sleep: assert property (p_cont_sleep)
    else $error("continuous sleep phase wrong");
  property p_start;
    o_conv_start && !i_cs_n && por_done_r |-> ##[0:2] (o_eoc && o_pins.sdo);
  endproperty
  a_start: assert property (p_start)
    else $error("data pin not high after new conversion");
  c_ext: cover property (o_conv_start &&
    o_clk_mode == adc_serial_pkg::MODE_EXT && por_done_r);
  c_test: cover property (o_pins.sck_oe && !o_pins.sck && $rose(i_cs_n));
  c_cont: cover property ($fell(o_eoc) &&
    o_clk_mode == adc_serial_pkg::MODE_INT_CONT);
endmodule
bind adc_serial_readout adc_serial_chk #(
  .POR_CYCLES(POR_CYCLES), .EXT_OSC_HZ(EXT_OSC_HZ),
  .RESULT_W(RESULT_W), .FIFO_DEPTH(FIFO_DEPTH)
) u_adc_serial_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cs_n(i_cs_n),
  .i_sck(i_sck), .i_ext_osc(i_ext_osc), .i_result_valid(i_result_valid),
  .i_result_data(i_result_data), .o_result_ready(o_result_ready),
  .o_conv_start(o_conv_start), .o_eoc(o_eoc), .o_clk_mode(o_clk_mode),
  .o_pins(o_pins)
);

// ==== dv/host_link.sv ====
// host side of the serial link: pin resolution and frame capture
`timescale 1ns/1ps
module host_link (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_host_oe,
  input  wire logic                     i_host_sck,
  input  wire logic                     i_clear,
  input  wire adc_serial_pkg::pin_out_t i_pins,
  output logic                          o_sck_wire,
  output logic [23:0]                   o_frame,
  output logic [5:0]                    o_bits
);
  logic held_r;
  logic sdo_r;
  logic sdo_w;
  // device, then host, then pull-up; else the pin keeps its level
  assign o_sck_wire = i_pins.sck_oe ? i_pins.sck : i_host_oe ? i_host_sck :
    i_pins.sck_pullup ? 1'b1 : held_r;
  // a released data line shows a changing pattern
  assign sdo_w = i_pins.sdo_oe ? i_pins.sdo : ~sdo_r;
  always_ff @(posedge i_core_clk)
  begin
    held_r <= o_sck_wire;
    sdo_r  <= sdo_w;
    if (i_clear)
      o_bits <= 6'h00;
    else if (o_sck_wire && !held_r)
    begin
      o_frame <= {o_frame[22:0], sdo_w};
      o_bits  <= o_bits + 6'h01;
    end
  end
endmodule

// ==== dv/testbench.sv ====
// self-checking testbench for the converter serial readout
`timescale 1ns/1ps
module testbench;
  localparam int W   = adc_serial_pkg::RESULT_W;
  localparam int POR = 20;
  localparam int HZ  = adc_serial_pkg::EXT_OSC_HZ_DEFAULT;
  localparam int EXT_DLY = (adc_serial_pkg::EXT_OSC_PERIODS_X10 *
    adc_serial_pkg::CLK_HZ + 10 * HZ - 1) / (10 * HZ);
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      cs_n = 1'b1;
  logic                      ext_osc = 1'b0;
  logic                      vld = 1'b0;
  logic [W-1:0]              data = 23'h000000;
  logic                      host_oe = 1'b1;
  logic                      host_sck = 1'b0;
  logic                      clr = 1'b0;
  logic                      sck_w;
  logic                      ready;
  logic                      start;
  logic                      eoc;
  adc_serial_pkg::clk_mode_t mode;
  adc_serial_pkg::pin_out_t  pins;
  logic [23:0]               frame;
  logic [5:0]                nbits;
  logic [W-1:0]              w;
  logic [W-1:0]              q[$];
  int                        err_count = 0;
  int                        checked = 0;
  int                        nstart = 0;
  int                        n0;
  int                        k;
  always #10 clk = ~clk;
  always @(posedge clk)
    if (start === 1'b1)
      nstart++;
  adc_serial_readout #(.POR_CYCLES(POR)) u_adc_serial_readout (
    .i_core_clk(clk), .i_reset(rst), .i_cs_n(cs_n), .i_sck(sck_w),
    .i_ext_osc(ext_osc), .i_result_valid(vld), .i_result_data(data),
    .o_result_ready(ready), .o_conv_start(start), .o_eoc(eoc),
    .o_clk_mode(mode), .o_pins(pins));
  host_link u_host_link (
    .i_core_clk(clk), .i_host_oe(host_oe), .i_host_sck(host_sck),
    .i_clear(clr), .i_pins(pins), .o_sck_wire(sck_w), .o_frame(frame),
    .o_bits(nbits));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic c, input string m);
    checked++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  function automatic logic [23:0] exp_frame(input logic [W-1:0] v);
    return {1'b0, v};
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rst_dut(input logic low);
    rst <= 1'b1;
    host_oe <= low;
    host_sck <= 1'b0;
    cyc(20);
    rst <= 1'b0;
    cyc(POR + 5);
  endtask
  task automatic push(input logic [W-1:0] v);
    vld <= 1'b1;
    data <= v;
    cyc(1);
    for (k = 0; k < 3000 && ready !== 1'b1; k++)
      cyc(1);
    chk(ready === 1'b1, "word not taken");
  endtask
  task automatic wait_bits(input logic [5:0] n);
    for (k = 0; k < 3000 && nbits !== n; k++)
      cyc(1);
  endtask
  task automatic lift_sck();
    cs_n <= 1'b1;
    host_oe <= 1'b1;
    host_sck <= 1'b1;
    cyc(4);
    host_oe <= 1'b0;
    cyc(4);
  endtask
  task automatic ext_frame(input logic [23:0] e);
    for (k = 0; k < 3000 && eoc !== 1'b0; k++)
      cyc(1);
    chk(pins.sdo === 1'b0 && pins.sdo_oe === 1'b1, "sleep flag");
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    repeat (24)
    begin
      host_sck <= 1'b1;
      cyc(4);
      host_sck <= 1'b0;
      cyc(4);
    end
    cyc(2);
    chk(frame === e && nbits === 6'h18, "external frame");
  endtask
  initial
  begin
    void'($urandom(73));
    rst_dut(1'b1);
    chk(mode === adc_serial_pkg::MODE_EXT, "external mode");
    cs_n <= 1'b0;
    q.push_back(23'h7fffff);
    q.push_back(23'h000001);
    repeat (7) q.push_back(W'($urandom));
    foreach (q[i]) push(q[i]);
    data <= 23'h2aaaaa;
    cyc(5);
    chk(ready === 1'b0, "full buffer took a word");
    vld <= 1'b0;
    foreach (q[i]) ext_frame(exp_frame(q[i]));
    cyc(10);
    chk(eoc === 1'b1 && pins.sdo === 1'b1, "new conversion");
    cs_n <= 1'b1;
    host_oe <= 1'b0;
    cyc(4);
    cs_n <= 1'b0;
    cyc(2);
    chk(mode === adc_serial_pkg::MODE_EXT, "released low clock");
    lift_sck();
    cs_n <= 1'b0;
    cyc(2);
    chk(mode === adc_serial_pkg::MODE_INT_SINGLE && pins.sck === 1'b0 &&
      pins.sdo === 1'b1, "single select");
    cs_n <= 1'b1;
    cyc(3);
    chk(pins.sdo_oe === 1'b0, "data pin not released");
    cs_n <= 1'b0;
    cyc(2);
    chk(mode === adc_serial_pkg::MODE_EXT, "low clock at select");
    lift_sck();
    w = W'($urandom);
    push(w);
    vld <= 1'b0;
    cyc(20);
    n0 = nstart;
    cs_n <= 1'b0;
    cyc(100);
    chk(pins.sck === 1'b0 && pins.sdo === 1'b0, "status test");
    cs_n <= 1'b1;
    cyc(3);
    chk(pins.sck_pullup === 1'b1 && nstart === n0, "test end");
    ext_osc <= 1'b1;
    clr <= 1'b1;
    cs_n <= 1'b0;
    cyc(1);
    clr <= 1'b0;
    for (k = 0; k < 3000 && !(pins.sck_oe === 1'b1 && pins.sck === 1'b1); k++)
      cyc(1);
    chk(k >= EXT_DLY - 4 && k <= EXT_DLY + 4, "status delay");
    wait_bits(6'h18);
    chk(frame === exp_frame(w), "held result frame");
    cyc(3);
    chk(pins.sck === 1'b1 && pins.sdo === 1'b1, "after frame");
    ext_osc <= 1'b0;
    clr <= 1'b1;
    push(W'($urandom));
    vld <= 1'b0;
    clr <= 1'b0;
    wait_bits(6'h05);
    n0 = nstart;
    cs_n <= 1'b1;
    cyc(4);
    chk(nstart === n0 + 1 && eoc === 1'b1, "aborted frame");
    cs_n <= 1'b0;
    rst_dut(1'b0);
    chk(mode === adc_serial_pkg::MODE_INT_CONT, "continuous");
    repeat (3)
    begin
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      w = W'($urandom);
      push(w);
      vld <= 1'b0;
      wait_bits(6'h18);
      chk(frame === exp_frame(w), "continuous frame");
    end
    tally_and_finish();
  end
  initial
  begin
    cyc(60000);
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
